//--- verif/pdhrd_checker.sv
// port-level checker for the power data and host register front end
`timescale 1ns/1ps

module pdhrd_checker (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host bus
  input wire pdhrd_pkg::pdhrd_req_t req,
  input wire pdhrd_pkg::pdhrd_rsp_t rsp,
  // core side
  input wire logic [63:0] node_uid,
  input wire logic pme_req,
  input wire logic func_irq_req,
  input wire logic card_mode_select_low,
  // outputs watched
  input wire logic card_status_change_out,
  input wire logic card_interrupt_out,
  input wire logic host_power_event_pin,
  input wire logic host_irq_line_a,
  input wire logic [31:0] host_control
);
  // upper id half, so the past value is taken of a plain signal
  logic [31:0] uid_hi;
  assign uid_hi = node_uid[63:32];

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  ////////////////////////////////////////////////////////////////////////
  a_ack_follows_req: assert property ((req.rd || req.wr) |=> rsp.ack)
    else $error("no answer one cycle after an access");
  a_no_stray_ack: assert property (!(req.rd || req.wr) |=> !rsp.ack)
    else $error("answer without an access");
  a_cfg_always_hits: assert property
    (req.cfg && (req.rd || req.wr) |=> rsp.hit)
    else $error("configuration access not decoded");
  a_bridge_byte_zero: assert property
    (req.rd && req.cfg && req.addr[7:2] == 6'h12 |=>
     rsp.rdata[23:16] == 8'h00)
    else $error("bridge support byte not zero");
  a_miss_reads_zero: assert property
    (rsp.ack && !rsp.hit |-> rsp.rdata == 32'h0000_0000)
    else $error("missed access returned data");
  a_set_ors_bits: assert property
    ((req.wr && !req.rd && !req.cfg && req.be == 4'hF &&
      req.addr[10:0] == pdhrd_pkg::OFS_HC_SET) ##1 rsp.hit |->
     host_control == ($past(host_control) | $past(req.wdata)))
    else $error("set port did not or in written ones");
  a_clear_masks_bits: assert property
    ((req.wr && !req.rd && !req.cfg && req.be == 4'hF &&
      req.addr[10:0] == pdhrd_pkg::OFS_HC_CLEAR) ##1 rsp.hit |->
     host_control == ($past(host_control) & ~$past(req.wdata)))
    else $error("clear port did not remove written ones");
  a_uid_high_live: assert property
    ((req.rd && !req.wr && !req.cfg &&
      req.addr[10:0] == pdhrd_pkg::OFS_UID_HIGH) ##1 rsp.hit |->
     rsp.rdata == $past(uid_hi))
    else $error("upper id half read wrong");
  // host mode: pins track the core requests within two cycles
  a_host_irq_follow: assert property
    (card_mode_select_low [*4] ##0 func_irq_req [*3] |->
     host_irq_line_a)
    else $error("host interrupt line not following request");
  a_pme_follow: assert property
    (card_mode_select_low [*4] ##0 pme_req [*3] |->
     host_power_event_pin)
    else $error("power event pin not following request");
  a_card_pins_quiet: assert property
    (card_mode_select_low [*4] |->
     !card_interrupt_out && !card_status_change_out)
    else $error("card pins active outside card mode");
endmodule : pdhrd_checker

bind pdhrd_top pdhrd_checker u_chk (
  .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .node_uid(node_uid),
  .pme_req(pme_req), .func_irq_req(func_irq_req),
  .card_mode_select_low(card_mode_select_low),
  .card_status_change_out(card_status_change_out),
  .card_interrupt_out(card_interrupt_out),
  .host_power_event_pin(host_power_event_pin),
  .host_irq_line_a(host_irq_line_a), .host_control(host_control)
);

//--- verif/pdhrd_host_model.sv
// host bus master model driving the register front end
`timescale 1ns/1ps

module pdhrd_host_model (
  // clock
  input wire logic clk,
  // access toward the front end
  output pdhrd_pkg::pdhrd_req_t req
);
  // bus idle from time zero
  initial begin
    req = '0;
  end

  // one access launched after an edge; no stall exists, so the next
  // edge takes it and may launch the following one back to back
  task automatic xfer(input logic cfg, input logic wr,
                      input logic [31:0] addr, input logic [31:0] wdata);
    @(posedge clk);
    req.rd <= ~wr;
    req.wr <= wr;
    req.cfg <= cfg;
    req.addr <= addr;
    req.wdata <= wdata;
    req.be <= 4'hF;
  endtask : xfer

  // release; address and data inverted so nothing stale lingers
  task automatic idle();
    @(posedge clk);
    req.rd <= 1'b0;
    req.wr <= 1'b0;
    req.addr <= ~req.addr;
    req.wdata <= ~req.wdata;
  endtask : idle
endmodule : pdhrd_host_model

//--- verif/pdhrd_top_test.sv
// self-checking bench of the power data and host register front end
`timescale 1ns/1ps

module pdhrd_top_test;
  // expected answer of one access
  typedef struct packed {
    logic chk_hit;
    logic hit;
    logic [31:0] data;
  } pdhrd_note_t;
  localparam logic [31:0] REV = 32'h0001_0001;
  localparam logic [31:0] MAKER = 32'h00AB_CDEF; // arbitrary value
  localparam logic [31:0] BNAME = 32'h3133_3934;
  localparam logic [31:0] HCMASK = 32'h0F0F_FFF0;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic card_sel_low = 1'b1;
  logic pme_req = 1'b0;
  logic func_irq_req = 1'b0;
  logic [63:0] node_uid = 64'h0123_4567_89AB_CDEF;
  logic [47:0] posted_addr = 48'hA5A5_1234_5678;
  pdhrd_pkg::pdhrd_load_t pm_load = '0;
  pdhrd_pkg::pdhrd_req_t req;
  pdhrd_pkg::pdhrd_rsp_t rsp;
  logic cso, cio, hpe, hia;
  logic [31:0] host_control;
  pdhrd_note_t notes[$];
  pdhrd_note_t n;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  logic [15:0] seed = 16'h0029;
  logic [7:0] pm_val [16];
  logic [1:0] pm_scl [16];
  logic [31:0] hc = 32'h0;
  logic [31:0] a;
  logic [10:0] ofs_tab [9];
  logic [31:0] val_tab [9];

  ////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  always #2.5 clk = ~clk;

  pdhrd_host_model host (.clk(clk), .req(req));

  pdhrd_top #(.REVISION_VALUE(REV), .MAKER_VALUE(MAKER),
    .BUS_NAME_VALUE(BNAME), .HC_CLEAR_READ_MASK(HCMASK)) uut (
    .clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .pm_load(pm_load),
    .node_uid(node_uid), .posted_addr(posted_addr), .pme_req(pme_req),
    .func_irq_req(func_irq_req), .card_mode_select_low(card_sel_low),
    .card_status_change_out(cso), .card_interrupt_out(cio),
    .host_power_event_pin(hpe), .host_irq_line_a(hia),
    .host_control(host_control));

  ////////////////////////////////////////////////////////////////////////
  // lfsr step, seed starts at 41
  function automatic logic [31:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return {seed, ~seed};
  endfunction : rnd

  // one compare, reported at once on mismatch
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // drive one access and note its expected answer
  task automatic op(input logic cfg, input logic wr, input logic [31:0] ad,
                    input logic [31:0] wd, input logic ch, input logic h,
                    input logic [31:0] d);
    host.xfer(cfg, wr, ad, wd);
    notes.push_back('{ch, h, d});
  endtask : op

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick

  task automatic tally_and_finish();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////
  // answer watcher: oldest note against each ack, mid-cycle when settled
  always @(negedge clk) begin
    if (rsp.ack === 1'b1) begin
      if (notes.size() == 0) begin
        check("stray_ack", 32'h0, 32'h1);
      end else begin
        n = notes.pop_front();
        if (n.chk_hit) check("hit", {31'h0, n.hit}, {31'h0, rsp.hit});
        check("rdata", n.data, rsp.rdata);
      end
    end
  end

  // hang guard, well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      $display("[ERR] run expected done seen hang");
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    tick(12);
    resetn <= 1'b1;
    op(1, 0, 32'h48, 0, 1, 1, 0);
    host.idle();
    // load sixteen entries; upper eight must not take
    for (int i = 0; i < 16; i++) begin
      a = rnd();
      @(posedge clk);
      pm_load <= '{1'b1, i[3:0], a[7:0], pdhrd_pkg::pdhrd_scale_t'(a[9:8])};
      pm_val[i] = (i < 8) ? a[7:0] : 8'h00;
      pm_scl[i] = (i < 8) ? a[9:8] : 2'b00;
    end
    @(posedge clk);
    pm_load.valid <= 1'b0;
    // every selector, select then read back to back
    for (int s = 0; s < 16; s++) begin
      op(1, 1, 32'h48, {19'h0, s[3:0], 9'h0}, 1, 1, 0);
      op(1, 0, 32'h48, 0, 1, 1,
        {pm_val[s], 8'h00, 1'b0, pm_scl[s], s[3:0], 9'h0});
    end
    // fixed and live words; id write must be ignored
    op(0, 1, 32'h24, rnd(), 0, 0, 0);
    ofs_tab = '{11'h000, 11'h01C, 11'h040, 11'h024, 11'h028, 11'h038,
      11'h03C, 11'h02C, 11'h030};
    val_tab = '{REV, BNAME, MAKER, node_uid[63:32], node_uid[31:0],
      posted_addr[31:0], {16'h0, posted_addr[47:32]}, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      op(0, 0, {21'h0, ofs_tab[i]}, 0, i < 7, 1, val_tab[i]);
    end
    a = rnd();
    op(0, 1, 32'h0C, a, 1, 1, 0);
    op(0, 0, 32'h0C, 0, 1, 1, a);
    // set and clear pair, both addresses read
    for (int i = 0; i < 4; i++) begin
      a = rnd();
      op(0, 1, 32'h50, a, 1, 1, 0);
      hc = hc | a;
      a = rnd();
      op(0, 1, 32'h54, a, 1, 1, 0);
      hc = hc & ~a;
      op(0, 0, 32'h50, 0, 1, 1, hc);
      op(0, 0, 32'h54, 0, 1, 1, hc & HCMASK);
    end
    host.idle();
    tick(2);
    check("host_control", hc, host_control);
    // move the host window; old place must miss with card mode off
    op(1, 1, 32'h10, 32'h0000_0800, 1, 1, 0);
    op(0, 0, 32'h800, 0, 1, 1, REV);
    op(0, 0, 32'h000, 0, 1, 0, 0);
    op(0, 0, 32'h854, 0, 1, 1, hc & HCMASK);
    host.idle();
    // card mode: registers appear, force drives shared pins
    card_sel_low <= 1'b0;
    tick(4);
    op(1, 1, 32'h14, 32'h0000_1000, 1, 1, 0);
    op(0, 1, 32'h1004, 32'h0000_8010, 1, 1, 0);
    op(0, 0, 32'h1004, 0, 1, 1, 32'h0000_8010);
    op(0, 1, 32'h100C, 32'h0000_8010, 1, 1, 0);
    op(0, 0, 32'h100C, 0, 1, 1, 0);
    host.idle();
    tick(3);
    check("card_irq", 32'h1, {31'h0, cio});
    check("irq_line", 32'h1, {31'h0, hia});
    check("card_chg", 32'h1, {31'h0, cso});
    check("pme_pin", 32'h1, {31'h0, hpe});
    op(0, 1, 32'h1000, 32'h0000_8010, 1, 1, 0);
    op(0, 0, 32'h1000, 0, 1, 1, 0);
    host.idle();
    card_sel_low <= 1'b1;
    tick(4);
    op(0, 0, 32'h1004, 0, 1, 0, 0);
    host.idle();
    // host mode: pins follow core requests
    pme_req <= 1'b1;
    func_irq_req <= 1'b1;
    tick(4);
    check("pme_host", 32'h1, {31'h0, hpe});
    check("irq_host", 32'h1, {31'h0, hia});
    tick(3);
    check("notes_left", 32'h0, notes.size());
    tally_and_finish();
  end
endmodule : pdhrd_top_test

//--- verilog/pdhrd_pkg.sv
// shared constants and carriers of the power data and host register decode
package pdhrd_pkg;

  // configuration space byte offsets
  localparam logic [7:0] CFG_OHCI_BAR = 8'h10;
  localparam logic [7:0] CFG_CARD_BAR = 8'h14;
  localparam logic [7:0] CFG_PM_CSR = 8'h48;
  localparam logic [7:0] CFG_PM_BRIDGE_EXT = 8'h4A;
  localparam logic [7:0] CFG_PM_POWER_DATA_BYTE = 8'h4B;

  // host controller window offsets, 2 Kbyte region
  localparam int OHCI_WIN_BITS = 11;
  localparam logic [10:0] OFS_REVISION = 11'h000;
  localparam logic [10:0] OFS_UID_ROM = 11'h004;
  localparam logic [10:0] OFS_RETRY = 11'h008;
  localparam logic [10:0] OFS_CSR_DATA = 11'h00C;
  localparam logic [10:0] OFS_CSR_COMPARE = 11'h010;
  localparam logic [10:0] OFS_CSR_COMMAND = 11'h014;
  localparam logic [10:0] OFS_ROM_HEADER = 11'h018;
  localparam logic [10:0] OFS_BUS_NAME = 11'h01C;
  localparam logic [10:0] OFS_BUS_OPTION = 11'h020;
  localparam logic [10:0] OFS_UID_HIGH = 11'h024;
  localparam logic [10:0] OFS_UID_LOW = 11'h028;
  localparam logic [10:0] OFS_ROM_BASE = 11'h034;
  localparam logic [10:0] OFS_PW_ADDR_LOW = 11'h038;
  localparam logic [10:0] OFS_PW_ADDR_HIGH = 11'h03C;
  localparam logic [10:0] OFS_MAKER = 11'h040;
  localparam logic [10:0] OFS_HC_SET = 11'h050;
  localparam logic [10:0] OFS_HC_CLEAR = 11'h054;

  // card function registers, 256 byte region behind the card base register
  localparam int CARD_WIN_BITS = 8;
  localparam logic [7:0] OFS_FN_EVENT = 8'h00;
  localparam logic [7:0] OFS_FN_MASK = 8'h04;
  localparam logic [7:0] OFS_FN_STATE = 8'h08;
  localparam logic [7:0] OFS_FN_FORCE = 8'h0C;

  // card function bit positions
  localparam int FN_WAKE_BIT = 4;
  localparam int FN_IRQ_BIT = 15;

  // power management control and status fields
  localparam int PM_STATE_LSB = 0;
  localparam int PM_SELECT_LSB = 9;
  localparam int PM_SCALE_LSB = 13;
  localparam logic [3:0] PM_SELECT_LAST_VALID = 4'h7;
  localparam int PM_ENTRIES = 16;
  localparam int PM_LOADABLE = 8;

  // reset and fixed values
  localparam logic [7:0] PM_POWER_DATA_BYTE_RESET = 8'h00;
  localparam logic [7:0] PM_BRIDGE_VALUE = 8'h00;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // data scale encodings
  typedef enum logic [1:0] {
    PDHRD_SCALE_UNKNOWN = 2'b00,
    PDHRD_SCALE_TENTH = 2'b01,
    PDHRD_SCALE_HUNDREDTH = 2'b10,
    PDHRD_SCALE_THOUSANDTH = 2'b11
  } pdhrd_scale_t;

  // one host bus access
  typedef struct packed {
    logic rd;
    logic wr;
    logic cfg;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } pdhrd_req_t;

  // answer, one cycle after the access
  typedef struct packed {
    logic ack;
    logic hit;
    logic [31:0] rdata;
  } pdhrd_rsp_t;

  // power data entry as loaded from the serial eeprom
  typedef struct packed {
    logic valid;
    logic [3:0] index;
    logic [7:0] value;
    pdhrd_scale_t scale;
  } pdhrd_load_t;

endpackage : pdhrd_pkg

//--- verilog/pdhrd_top.sv
// register front end: power data, card function and host window decode
//
// How it works
// [R1] bridge support byte always reads zero
// [R2] sixteen power data bytes, zero by default
// [R3] only entries zero to seven load from eeprom
// [R4] select field indexes reported power entry
// [R5] scale field: unknown, tenth, hundredth, thousandth
// [R6] selector eight to fifteen reads zero
// [R7] eeprom image keeps standby power exclusive
// [R8] four 32-bit card function registers
// [R9] card registers answer only when select low
// [R10] status change and card interrupt outputs
// [R11] host window is 2 Kbyte at 10h
// [R12] set address sets bits written one
// [R13] clear address clears bits written one
// [R14] either pair address reads shared register
// [R15] clear address read may return masked
// [R16] decode version, retries, csr, posted, control
// [R17] unique id rom access at 04h
// [R18] unique id halves at 24h/28h, reserved after
// [R19] select bits 12:9, scale bits 14:13
`timescale 1ns/1ps

module pdhrd_top #(
  parameter logic [31:0] REVISION_VALUE = 32'h0001_0001,
  parameter logic [31:0] MAKER_VALUE = 32'h0012_3456, // arbitrary value
  parameter logic [31:0] BUS_NAME_VALUE = 32'h3133_3934,
  parameter logic [31:0] HC_CLEAR_READ_MASK = 32'hFFFF_FFFF
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // host bus access and answer
  input wire pdhrd_pkg::pdhrd_req_t req,
  output pdhrd_pkg::pdhrd_rsp_t rsp,
  // eeprom power data load
  input wire pdhrd_pkg::pdhrd_load_t pm_load,
  // identity and link state from the controller core
  input wire logic [63:0] node_uid,
  input wire logic [47:0] posted_addr,
  input wire logic pme_req,
  input wire logic func_irq_req,
  // mode strap pin
  input wire logic card_mode_select_low,
  // event pins; power event pin and line a shared between card and host modes
  output logic card_status_change_out,
  output logic card_interrupt_out,
  output logic host_power_event_pin,
  output logic host_irq_line_a,
  // host control register contents for the core
  output logic [31:0] host_control
);

  ////////////////////////////////////////////////////////////////////////
  // declarations

  // mode pin synchroniser, first stage read only by second
  logic mode_meta;
  logic mode_sync;
  logic card_mode;
  // configuration state
  logic [31:0] ohci_bar; // base of the 2 Kbyte window
  logic [31:0] card_bar; // base of the card function window
  logic [1:0] pm_state; // power state field
  logic [3:0] pm_select; // data select field
  // power data complex
  logic [7:0] pm_value [pdhrd_pkg::PM_ENTRIES];
  pdhrd_pkg::pdhrd_scale_t pm_scale [pdhrd_pkg::PM_LOADABLE];
  logic [7:0] sel_value; // byte reported at 4Bh
  pdhrd_pkg::pdhrd_scale_t sel_scale; // scale reported in csr
  // host window storage
  logic [31:0] uid_rom;
  logic [31:0] retry;
  logic [31:0] csr_data;
  logic [31:0] csr_compare;
  logic [31:0] csr_command;
  logic [31:0] rom_header;
  logic [31:0] bus_option;
  logic [31:0] rom_base;
  logic [31:0] hc_reg; // shared register of the set/clear pair
  // card function registers
  logic [31:0] fn_event;
  logic [31:0] fn_mask;
  logic [31:0] fn_state;
  // decode
  logic [31:0] wmask; // byte lanes as a bit mask
  logic [31:0] wbits; // written data under the lanes
  logic ohci_hit;
  logic card_hit;
  logic [10:0] ohci_ofs;
  logic [7:0] card_ofs;
  logic [7:0] cfg_ofs;
  logic ohci_wr;
  logic card_wr;
  logic cfg_wr;
  logic hit;
  logic [31:0] next_rdata;
  logic [31:0] fn_set; // hardware event sources this cycle

  ////////////////////////////////////////////////////////////////////////
  // mode pin and shared decode

  // two flops before anything looks at the strap pin
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_meta <= 1'b1;
      mode_sync <= 1'b1;
    end else begin
      mode_meta <= card_mode_select_low;
      mode_sync <= mode_meta;
    end
  end

  assign card_mode = !mode_sync;

  // byte enables spread to bits; only enabled lanes change
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{req.be[i]}};
    end
    wbits = req.wdata & wmask;
  end

  assign cfg_ofs = {req.addr[7:2], 2'b00};
  assign ohci_ofs = {req.addr[10:2], 2'b00};
  assign card_ofs = {req.addr[7:2], 2'b00};
  // window compare on the upper address bits
  assign ohci_hit = !req.cfg &&
    (req.addr[31:pdhrd_pkg::OHCI_WIN_BITS] ==
     ohci_bar[31:pdhrd_pkg::OHCI_WIN_BITS]); // R11
  // card window silent unless the select pin is low
  assign card_hit = !req.cfg && card_mode && !ohci_hit &&
    (req.addr[31:pdhrd_pkg::CARD_WIN_BITS] ==
     card_bar[31:pdhrd_pkg::CARD_WIN_BITS]); // R9
  assign cfg_wr = req.wr && req.cfg;
  assign ohci_wr = req.wr && ohci_hit;
  assign card_wr = req.wr && card_hit;
  assign hit = req.cfg || ohci_hit || card_hit;

  ////////////////////////////////////////////////////////////////////////
  // configuration space

  // base registers: window size bits read back as zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ohci_bar <= pdhrd_pkg::WORD_ZERO;
      card_bar <= pdhrd_pkg::WORD_ZERO;
    end else if (cfg_wr && cfg_ofs == pdhrd_pkg::CFG_OHCI_BAR) begin
      ohci_bar[31:pdhrd_pkg::OHCI_WIN_BITS] <=
        wbits[31:pdhrd_pkg::OHCI_WIN_BITS] |
        (ohci_bar[31:pdhrd_pkg::OHCI_WIN_BITS] &
         ~wmask[31:pdhrd_pkg::OHCI_WIN_BITS]); // R11
    end else if (cfg_wr && cfg_ofs == pdhrd_pkg::CFG_CARD_BAR) begin
      card_bar[31:pdhrd_pkg::CARD_WIN_BITS] <=
        wbits[31:pdhrd_pkg::CARD_WIN_BITS] |
        (card_bar[31:pdhrd_pkg::CARD_WIN_BITS] &
         ~wmask[31:pdhrd_pkg::CARD_WIN_BITS]);
    end
  end

  // power state and data select, in the low half of the 48h word
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pm_state <= 2'b00;
      pm_select <= 4'h0;
    end else if (cfg_wr && cfg_ofs == pdhrd_pkg::CFG_PM_CSR) begin
      if (req.be[0]) begin
        pm_state <= req.wdata[pdhrd_pkg::PM_STATE_LSB +: 2];
      end
      // select sits in lane one only, bits 12:9
      if (req.be[1]) begin
        pm_select <= req.wdata[pdhrd_pkg::PM_SELECT_LSB +: 4]; // R19
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power data complex

  // eeprom loads reach only the lower eight entries
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < pdhrd_pkg::PM_ENTRIES; i++) begin
        pm_value[i] <= pdhrd_pkg::PM_POWER_DATA_BYTE_RESET; // R2
      end
      for (int i = 0; i < pdhrd_pkg::PM_LOADABLE; i++) begin
        pm_scale[i] <= pdhrd_pkg::PDHRD_SCALE_UNKNOWN;
      end
    end else if (pm_load.valid &&
                 pm_load.index <= pdhrd_pkg::PM_SELECT_LAST_VALID) begin
      // upper entries stay zero: reserved for multifunction parts
      pm_value[pm_load.index] <= pm_load.value; // R3
      pm_scale[pm_load.index[2:0]] <= pm_load.scale; // R5
    end
  end

  // selected entry; reserved selectors report zero and unknown scale
  always_comb begin
    if (pm_select <= pdhrd_pkg::PM_SELECT_LAST_VALID) begin
      // 0..3 consumed, 4..7 dissipated, D0..D3 each
      sel_value = pm_value[pm_select]; // R4
      sel_scale = pm_scale[pm_select[2:0]]; // R5
    end else begin
      sel_value = pdhrd_pkg::PM_POWER_DATA_BYTE_RESET; // R6
      sel_scale = pdhrd_pkg::PDHRD_SCALE_UNKNOWN; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // host window storage

  // plain read/write words, byte lanes honoured
  always_ff @(posedge clk) begin
    if (!resetn) begin
      uid_rom <= pdhrd_pkg::WORD_ZERO;
      retry <= pdhrd_pkg::WORD_ZERO;
      csr_data <= pdhrd_pkg::WORD_ZERO;
      csr_compare <= pdhrd_pkg::WORD_ZERO;
      csr_command <= pdhrd_pkg::WORD_ZERO;
      rom_header <= pdhrd_pkg::WORD_ZERO;
      bus_option <= pdhrd_pkg::WORD_ZERO;
      rom_base <= pdhrd_pkg::WORD_ZERO;
    end else if (ohci_wr) begin
      case (ohci_ofs)
        pdhrd_pkg::OFS_UID_ROM: begin
          uid_rom <= wbits | (uid_rom & ~wmask); // R17
        end
        pdhrd_pkg::OFS_RETRY: begin
          retry <= wbits | (retry & ~wmask); // R16
        end
        pdhrd_pkg::OFS_CSR_DATA: begin
          csr_data <= wbits | (csr_data & ~wmask);
        end
        pdhrd_pkg::OFS_CSR_COMPARE: begin
          csr_compare <= wbits | (csr_compare & ~wmask); // R16
        end
        pdhrd_pkg::OFS_CSR_COMMAND: begin
          csr_command <= wbits | (csr_command & ~wmask); // R16
        end
        pdhrd_pkg::OFS_ROM_HEADER: begin
          rom_header <= wbits | (rom_header & ~wmask);
        end
        pdhrd_pkg::OFS_BUS_OPTION: begin
          bus_option <= wbits | (bus_option & ~wmask);
        end
        pdhrd_pkg::OFS_ROM_BASE: begin
          rom_base <= wbits | (rom_base & ~wmask);
        end
        default: begin
          // read-only or reserved words ignore writes
        end
      endcase
    end
  end

  // set/clear pair on one register; a write of zero bits does nothing
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hc_reg <= pdhrd_pkg::WORD_ZERO;
    end else if (ohci_wr && ohci_ofs == pdhrd_pkg::OFS_HC_SET) begin
      hc_reg <= hc_reg | wbits; // R12
    end else if (ohci_wr && ohci_ofs == pdhrd_pkg::OFS_HC_CLEAR) begin
      hc_reg <= hc_reg & ~wbits; // R13
    end
  end

  assign host_control = hc_reg;

  ////////////////////////////////////////////////////////////////////////
  // card function registers

  // sources: functional interrupt and wake request
  always_comb begin
    fn_set = pdhrd_pkg::WORD_ZERO;
    fn_set[pdhrd_pkg::FN_IRQ_BIT] = func_irq_req;
    fn_set[pdhrd_pkg::FN_WAKE_BIT] = pme_req;
  end

  // present state follows the sources one cycle late
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fn_state <= pdhrd_pkg::WORD_ZERO;
    end else begin
      fn_state <= fn_set; // R8
    end
  end

  // sticky events: a source or force write wins over a clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fn_event <= pdhrd_pkg::WORD_ZERO;
    end else if (card_wr && card_ofs == pdhrd_pkg::OFS_FN_EVENT) begin
      fn_event <= (fn_event & ~wbits) | fn_set; // R8
    end else if (card_wr && card_ofs == pdhrd_pkg::OFS_FN_FORCE) begin
      fn_event <= fn_event | fn_set | wbits; // R8
    end else begin
      fn_event <= fn_event | fn_set;
    end
  end

  // mask gates events onto the card pins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fn_mask <= pdhrd_pkg::WORD_ZERO;
    end else if (card_wr && card_ofs == pdhrd_pkg::OFS_FN_MASK) begin
      fn_mask <= wbits | (fn_mask & ~wmask); // R8
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event pins

  // card mode steers status change onto the power event pin and the
  // function interrupt onto line a; host mode passes the core requests
  always_ff @(posedge clk) begin
    if (!resetn) begin
      card_status_change_out <= 1'b0;
      card_interrupt_out <= 1'b0;
      host_power_event_pin <= 1'b0;
      host_irq_line_a <= 1'b0;
    end else begin
      card_status_change_out <= card_mode &&
        fn_event[pdhrd_pkg::FN_WAKE_BIT] &&
        fn_mask[pdhrd_pkg::FN_WAKE_BIT]; // R10
      card_interrupt_out <= card_mode &&
        fn_event[pdhrd_pkg::FN_IRQ_BIT] &&
        fn_mask[pdhrd_pkg::FN_IRQ_BIT]; // R10
      host_power_event_pin <= card_mode ?
        (fn_event[pdhrd_pkg::FN_WAKE_BIT] &&
         fn_mask[pdhrd_pkg::FN_WAKE_BIT]) : pme_req; // R10
      host_irq_line_a <= card_mode ?
        (fn_event[pdhrd_pkg::FN_IRQ_BIT] &&
         fn_mask[pdhrd_pkg::FN_IRQ_BIT]) : func_irq_req; // R10
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read path

  // unmapped and reserved words read zero
  always_comb begin
    next_rdata = pdhrd_pkg::WORD_ZERO;
    if (req.cfg) begin
      case (cfg_ofs)
        pdhrd_pkg::CFG_OHCI_BAR: next_rdata = ohci_bar; // R11
        pdhrd_pkg::CFG_CARD_BAR: next_rdata = card_bar;
        pdhrd_pkg::CFG_PM_CSR: begin
          next_rdata[31:24] = sel_value; // R2
          next_rdata[23:16] = pdhrd_pkg::PM_BRIDGE_VALUE; // R1
          next_rdata[pdhrd_pkg::PM_SCALE_LSB +: 2] = sel_scale; // R19
          next_rdata[pdhrd_pkg::PM_SELECT_LSB +: 4] = pm_select; // R19
          next_rdata[pdhrd_pkg::PM_STATE_LSB +: 2] = pm_state;
        end
        default: next_rdata = pdhrd_pkg::WORD_ZERO;
      endcase
    end else if (ohci_hit) begin
      case (ohci_ofs)
        pdhrd_pkg::OFS_REVISION: next_rdata = REVISION_VALUE; // R16
        pdhrd_pkg::OFS_UID_ROM: next_rdata = uid_rom; // R17
        pdhrd_pkg::OFS_RETRY: next_rdata = retry;
        pdhrd_pkg::OFS_CSR_DATA: next_rdata = csr_data;
        pdhrd_pkg::OFS_CSR_COMPARE: next_rdata = csr_compare;
        pdhrd_pkg::OFS_CSR_COMMAND: next_rdata = csr_command;
        pdhrd_pkg::OFS_ROM_HEADER: next_rdata = rom_header;
        pdhrd_pkg::OFS_BUS_NAME: next_rdata = BUS_NAME_VALUE;
        pdhrd_pkg::OFS_BUS_OPTION: next_rdata = bus_option;
        pdhrd_pkg::OFS_UID_HIGH: next_rdata = node_uid[63:32]; // R18
        pdhrd_pkg::OFS_UID_LOW: next_rdata = node_uid[31:0]; // R18
        pdhrd_pkg::OFS_ROM_BASE: next_rdata = rom_base;
        pdhrd_pkg::OFS_PW_ADDR_LOW: next_rdata = posted_addr[31:0]; // R16
        pdhrd_pkg::OFS_PW_ADDR_HIGH: begin
          next_rdata[15:0] = posted_addr[47:32]; // R16
        end
        pdhrd_pkg::OFS_MAKER: next_rdata = MAKER_VALUE;
        pdhrd_pkg::OFS_HC_SET: next_rdata = hc_reg; // R14
        pdhrd_pkg::OFS_HC_CLEAR: begin
          next_rdata = hc_reg & HC_CLEAR_READ_MASK; // R15
        end
        default: next_rdata = pdhrd_pkg::WORD_ZERO; // R18
      endcase
    end else if (card_hit) begin
      case (card_ofs)
        pdhrd_pkg::OFS_FN_EVENT: next_rdata = fn_event; // R8
        pdhrd_pkg::OFS_FN_MASK: next_rdata = fn_mask; // R8
        pdhrd_pkg::OFS_FN_STATE: next_rdata = fn_state; // R8
        default: next_rdata = pdhrd_pkg::WORD_ZERO; // force reads zero
      endcase
    end
  end

  // answer registered one cycle after every access
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rsp <= '0;
    end else begin
      rsp.ack <= req.rd || req.wr;
      rsp.hit <= (req.rd || req.wr) && hit; // R9
      rsp.rdata <= req.rd ? next_rdata : pdhrd_pkg::WORD_ZERO;
    end
  end

endmodule : pdhrd_top
